// >>> logic/periodic_tick_down_counter.sv
// Periodic tick down counter with control/status, reload, current value and
// calibration registers on the core's register port.
// Assumes one core clock, an active-low asynchronous reset, and a calibration
// source that is already synchronous to the core clock.
`timescale 1ns/1ps

module periodic_tick_down_counter #(
    parameter int unsigned REF_RATIO = tick_pkg::REF_DIV_RATIO
) (
    input  wire logic                             clk,
    input  wire logic                             nrst,
    input  wire tick_pkg::bus_req_t               bus_req,
    output tick_pkg::bus_rsp_t                    bus_rsp,
    input  wire logic [tick_pkg::DATA_W-1:0]      calibration_source,
    output logic [tick_pkg::COUNT_W-1:0]          calibration_default,
    output logic                                  zero_reach_irq,
    output logic                                  zero_event,
    output logic [tick_pkg::COUNT_W-1:0]          count_value,
    output logic                                  counter_running
);

    tick_pkg::counter_state_t state_reg;
    tick_pkg::counter_state_t state_next;

    logic ref_tick;
    logic count_tick;
    logic reaches_zero;
    logic csr_read;
    logic csr_write;
    logic reload_write;
    logic current_write;

    // True when the request is a valid access of the given kind at the offset.
    function automatic logic access_hit(
        input tick_pkg::bus_req_t          req,
        input logic                        is_write,
        input logic [tick_pkg::ADDR_W-1:0] offset
    );
        access_hit = req.valid && (req.write == is_write) && (req.addr == offset);
    endfunction

    // Reference tick at half the core rate.
    tick_clock_divider #(
        .RATIO (REF_RATIO)
    ) u_tick_clock_divider (
        .clk      (clk),
        .nrst     (nrst),
        .ref_tick (ref_tick)
    );

    always_comb begin
        state_next            = state_reg;
        state_next.rsp_valid  = 1'b0;
        state_next.rdata      = '0;
        state_next.irq        = 1'b0;
        state_next.zero_event = 1'b0;
        reaches_zero          = 1'b0;

        csr_read      = access_hit(bus_req, 1'b0, tick_pkg::CSR_OFFSET);
        csr_write     = access_hit(bus_req, 1'b1, tick_pkg::CSR_OFFSET);
        reload_write  = access_hit(bus_req, 1'b1, tick_pkg::RELOAD_OFFSET);
        current_write = access_hit(bus_req, 1'b1, tick_pkg::CURRENT_OFFSET);

        // Core clock when selected, otherwise the divided reference tick.
        count_tick = state_reg.count_clock_select ? 1'b1 : ref_tick;

        // A zero count loads the reload value on the next tick, so the period
        // is reload plus one ticks and a reload of zero never fires.
        if (state_reg.enable && count_tick) begin
            if (state_reg.current == '0) begin
                state_next.current = state_reg.reload;
            end else begin
                state_next.current = state_reg.current - 1'b1;
                reaches_zero       = (state_reg.current == 24'h00_0001);
            end
        end

        // Control writes; the status flag bit is read-only.
        if (csr_write) begin
            state_next.enable                = bus_req.wdata[tick_pkg::ENABLE_BIT];
            state_next.zero_reach_irq_enable = bus_req.wdata[tick_pkg::IRQ_ENABLE_BIT];
            state_next.count_clock_select    = bus_req.wdata[tick_pkg::CLK_SELECT_BIT];
        end

        if (reload_write) begin
            state_next.reload = bus_req.wdata[tick_pkg::COUNT_MSB:0];
        end

        // A write overrides a decrement in the same cycle.
        if (current_write) begin
            state_next.current = tick_pkg::CURRENT_RESET;
        end

        // Reading status or writing the count clears the flag.
        if (csr_read || current_write) begin
            state_next.reached_zero_flag = 1'b0;
        end

        // A new reach of zero wins over a clear in the same cycle.
        if (reaches_zero) begin
            state_next.reached_zero_flag = 1'b1;
            state_next.zero_event        = 1'b1;
            state_next.irq               = state_reg.zero_reach_irq_enable;
        end

        // Calibration follows its source register once out of reset.
        state_next.calibration = calibration_source;

        // Read data answers one cycle after the request; unmapped reads give zero.
        if (bus_req.valid && !bus_req.write) begin
            state_next.rsp_valid = 1'b1;
            if (bus_req.addr == tick_pkg::CSR_OFFSET) begin
                state_next.rdata[tick_pkg::ENABLE_BIT]     = state_reg.enable;
                state_next.rdata[tick_pkg::IRQ_ENABLE_BIT] = state_reg.zero_reach_irq_enable;
                state_next.rdata[tick_pkg::CLK_SELECT_BIT] = state_reg.count_clock_select;
                state_next.rdata[tick_pkg::FLAG_BIT]       = state_reg.reached_zero_flag;
            end else if (bus_req.addr == tick_pkg::RELOAD_OFFSET) begin
                state_next.rdata[tick_pkg::COUNT_MSB:0] = state_reg.reload;
            end else if (bus_req.addr == tick_pkg::CURRENT_OFFSET) begin
                state_next.rdata[tick_pkg::COUNT_MSB:0] = state_reg.current;
            end else if (bus_req.addr == tick_pkg::CALIB_OFFSET) begin
                state_next.rdata = state_reg.calibration & tick_pkg::CALIB_READ_MASK;
            end else begin
                state_next.rdata = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg                       <= '0;
            state_reg.enable                <= tick_pkg::CSR_RESET[tick_pkg::ENABLE_BIT];
            state_reg.zero_reach_irq_enable <= tick_pkg::CSR_RESET[tick_pkg::IRQ_ENABLE_BIT];
            state_reg.count_clock_select    <= tick_pkg::CSR_RESET[tick_pkg::CLK_SELECT_BIT];
            state_reg.reached_zero_flag     <= tick_pkg::CSR_RESET[tick_pkg::FLAG_BIT];
            state_reg.reload                <= tick_pkg::RELOAD_RESET;
            state_reg.current               <= tick_pkg::CURRENT_RESET;
            state_reg.calibration           <= tick_pkg::CALIB_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus_rsp.valid       = state_reg.rsp_valid;
    assign bus_rsp.rdata       = state_reg.rdata;
    assign zero_reach_irq      = state_reg.irq;
    assign zero_event          = state_reg.zero_event;
    assign count_value         = state_reg.current;
    assign counter_running     = state_reg.enable;
    // Offered to the configuration block as its ten-millisecond default.
    assign calibration_default = tick_pkg::TEN_MS_CAL_DEFAULT;

endmodule

// >>> logic/tick_clock_divider.sv
// Reference tick generator: one-cycle enable pulse once every RATIO core clocks.
// Assumes it shares the core clock and reset with the counter it feeds.
`timescale 1ns/1ps

module tick_clock_divider #(
    parameter int unsigned RATIO = tick_pkg::REF_DIV_RATIO
) (
    input  wire logic clk,
    input  wire logic nrst,
    output logic      ref_tick
);

    localparam logic [tick_pkg::DIV_CNT_W-1:0] LAST = tick_pkg::DIV_CNT_W'(RATIO - 1);

    tick_pkg::divider_state_t state_reg;
    tick_pkg::divider_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (state_reg.count == LAST) begin
            state_next.count = '0;
        end else begin
            state_next.count = state_reg.count + 1'b1;
        end
        state_next.tick = (state_reg.count == LAST);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ref_tick = state_reg.tick;

endmodule

// >>> logic/tick_pkg.sv
// Shared constants and carrier types for the periodic tick down counter.
// Assumes a single clock domain, the core clock, at the rate given below.
package tick_pkg;

    localparam int unsigned ADDR_W  = 12;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned COUNT_W = 24;

    // Register offsets on the core's private peripheral register port.
    localparam logic [ADDR_W-1:0] CSR_OFFSET     = 12'h010;
    localparam logic [ADDR_W-1:0] RELOAD_OFFSET  = 12'h014;
    localparam logic [ADDR_W-1:0] CURRENT_OFFSET = 12'h018;
    localparam logic [ADDR_W-1:0] CALIB_OFFSET   = 12'h01C;

    // Field positions.
    localparam int unsigned ENABLE_BIT     = 0;
    localparam int unsigned IRQ_ENABLE_BIT = 1;
    localparam int unsigned CLK_SELECT_BIT = 2;
    localparam int unsigned FLAG_BIT       = 16;
    localparam int unsigned COUNT_MSB      = 23;
    localparam int unsigned SKEW_BIT       = 30;
    localparam int unsigned REFERENCE_ABSENT_FLAG_BIT      = 31;

    // Values after reset.
    localparam logic [DATA_W-1:0]  CSR_RESET     = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] RELOAD_RESET  = 24'h00_0000;
    localparam logic [COUNT_W-1:0] CURRENT_RESET = 24'h00_0000;
    localparam logic [DATA_W-1:0]  CALIB_RESET   = 32'h0000_0004;

    // Mask of the calibration bits that read back; bits 29:24 read as zero.
    localparam logic [DATA_W-1:0]  CALIB_READ_MASK = 32'hC0FF_FFFF;

    // Clocking: core clock and the fixed half-rate reference clock.
    localparam int unsigned CPU_CLK_MHZ   = 125;
    localparam int unsigned REF_DIV_RATIO = 2;
    localparam int unsigned DIV_CNT_W     = 8;

    // Ten millisecond interval counted at the 50 MHz calibration target clock, not the 125 MHz core clock.
    localparam int unsigned CAL_TARGET_MHZ = 50;
    localparam int unsigned TEN_MS_US      = 10000;
    localparam logic [COUNT_W-1:0] TEN_MS_CAL_DEFAULT = COUNT_W'(CAL_TARGET_MHZ * TEN_MS_US - 1);

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } bus_rsp_t;

    typedef struct packed {
        logic                 enable;
        logic                 zero_reach_irq_enable;
        logic                 count_clock_select;
        logic                 reached_zero_flag;
        logic [COUNT_W-1:0]   reload;
        logic [COUNT_W-1:0]   current;
        logic [DATA_W-1:0]    calibration;
        logic                 rsp_valid;
        logic [DATA_W-1:0]    rdata;
        logic                 irq;
        logic                 zero_event;
    } counter_state_t;

    typedef struct packed {
        logic [DIV_CNT_W-1:0] count;
        logic                 tick;
    } divider_state_t;

endpackage

// >>> sim/periodic_tick_properties.sv
// Port-level checks for the periodic tick down counter.
// Assumes one core clock and the active-low asynchronous reset.
`timescale 1ns/1ps

module periodic_tick_properties #(
    parameter int unsigned REF_RATIO = 2
) (
    input wire logic                         clk,
    input wire logic                         nrst,
    input wire tick_pkg::bus_req_t           bus_req,
    input wire tick_pkg::bus_rsp_t           bus_rsp,
    input wire logic [tick_pkg::DATA_W-1:0]  calibration_source,
    input wire logic [tick_pkg::COUNT_W-1:0] calibration_default,
    input wire logic                         zero_reach_irq,
    input wire logic                         zero_event,
    input wire logic [tick_pkg::COUNT_W-1:0] count_value,
    input wire logic                         counter_running
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic rd_req = bus_req.valid && !bus_req.write;
    wire logic cv_wr  = bus_req.valid && bus_req.write && bus_req.addr == tick_pkg::CURRENT_OFFSET;
    sequence s_one_to_zero;
        $past(count_value) == 24'h00_0001 ##0 count_value == 24'h00_0000;
    endsequence
    chk_read_answer: assert property (rd_req |=> bus_rsp.valid)
        else $error("read not answered");
    chk_no_stray: assert property (!rd_req |=> !bus_rsp.valid)
        else $error("answer without read");
    chk_idle_rdata: assert property (!bus_rsp.valid |-> bus_rsp.rdata == 32'h0000_0000)
        else $error("read data while idle");
    chk_event_cause: assert property (zero_event |-> s_one_to_zero)
        else $error("event without reach of zero");
    chk_event_pulse: assert property (zero_event |=> !zero_event)
        else $error("event longer than a cycle");
    chk_irq_event: assert property (zero_reach_irq |-> zero_event)
        else $error("irq without event");
    chk_halt_hold: assert property (!counter_running && !cv_wr |=> $stable(count_value))
        else $error("count moved while halted");
    chk_step_one: assert property (counter_running && count_value > 24'h00_0001 && !cv_wr |=>
        count_value == $past(count_value) || count_value == $past(count_value) - 24'h00_0001)
        else $error("count step not one");
    chk_cv_clear: assert property (cv_wr |=> count_value == 24'h00_0000)
        else $error("current write did not clear");
    chk_cal_default: assert property (calibration_default == 24'h07_A11F)
        else $error("calibration default wrong");
endmodule

bind periodic_tick_down_counter periodic_tick_properties #(.REF_RATIO(REF_RATIO)) u_props (
    .clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .calibration_source(calibration_source), .calibration_default(calibration_default),
    .zero_reach_irq(zero_reach_irq), .zero_event(zero_event),
    .count_value(count_value), .counter_running(counter_running));

// >>> sim/tb_top.sv
// Self-checking bench for the periodic tick down counter.
// Assumes the port checker is bound in from its own file.
`timescale 1ns/1ps

module tb_top;
    logic                         clk = 1'b0;
    logic                         nrst = 1'b0;
    tick_pkg::bus_req_t           bus_req = '0;
    tick_pkg::bus_rsp_t           bus_rsp;
    logic [tick_pkg::DATA_W-1:0]  calibration_source = 32'hFF12_3456;
    logic [tick_pkg::COUNT_W-1:0] calibration_default;
    logic                         zero_reach_irq;
    logic                         zero_event;
    logic [tick_pkg::COUNT_W-1:0] count_value;
    logic                         counter_running;
    logic [31:0]                  rd;
    int                           miscompares = 0;
    int                           n_checks = 0;

    always #4 clk = ~clk;

    periodic_tick_down_counter #(.REF_RATIO(2)) DUT (
        .clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .calibration_source(calibration_source), .calibration_default(calibration_default),
        .zero_reach_irq(zero_reach_irq), .zero_event(zero_event),
        .count_value(count_value), .counter_running(counter_running));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) bus_req <= '{1'b1, 1'b1, a, d};
        @(posedge clk) bus_req.valid <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a);
        @(posedge clk) bus_req <= '{1'b1, 1'b0, a, 32'h0000_0000};
        @(posedge clk) bus_req.valid <= 1'b0;
        #1 rd = bus_rsp.rdata;
        check("rsp_valid", bus_rsp.valid, 1'b1);
    endtask

    // Counts cycles between two successive zero events.
    task automatic period(input int exp, input logic irq);
        int n;
        n = 0;
        // Only events launched after the caller's last edge count as the start.
        do begin
            @(posedge clk);
            #1 n++;
        end while (zero_event !== 1'b1 && n < 200);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (zero_event !== 1'b1 && n < 200);
        check("period", n, exp);
        check("irq", zero_reach_irq, irq);
    endtask

    task automatic t_reset_values();
        logic [11:0] a [5] = '{12'h010, 12'h014, 12'h018, 12'h01C, 12'h020};
        logic [31:0] e [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hC012_3456, 32'h0000_0000};
        // Reads calibration at the release edge, before it first follows its source.
        bus_req <= '{1'b1, 1'b0, 12'h01C, 32'h0000_0000};
        @(posedge clk) bus_req.valid <= 1'b0;
        #1 check("cal_reset", bus_rsp.rdata, 32'h0000_0004);
        foreach (a[i]) begin
            rd_reg(a[i]);
            check("reset_read", rd, e[i]);
        end
        check("cal_default", calibration_default, 32'h0007_A11F);
    endtask

    task automatic t_core_clock();
        logic [23:0] held;
        wr(12'h014, 32'h0000_0003);
        wr(12'h018, 32'h0000_0000);
        wr(12'h010, 32'h0000_0007);
        period(4, 1'b1);
        check("running", counter_running, 1'b1);
        wr(12'h010, 32'h0000_0000);
        rd_reg(12'h010);
        check("flag_set", rd[16], 1'b1);
        rd_reg(12'h010);
        check("flag_clear", rd[16], 1'b0);
        held = count_value;
        repeat (10) @(posedge clk);
        #1 check("halted", count_value, held);
        check("stopped", counter_running, 1'b0);
        rd_reg(12'h018);
        check("live_count", rd, {8'h00, held});
    endtask

    task automatic t_ref_clock();
        wr(12'h018, 32'h0000_0000);
        wr(12'h010, 32'h0000_0003);
        period(8, 1'b1);
    endtask

    task automatic t_irq_off();
        wr(12'h010, 32'h0000_0005);
        period(4, 1'b0);
    endtask

    task automatic t_cvr_clear();
        wr(12'h014, 32'h0000_0064);
        repeat (20) @(posedge clk);
        wr(12'h018, 32'h0000_1234);
        rd_reg(12'h010);
        check("flag_wr_clear", rd[16], 1'b0);
        check("reloaded", count_value > 24'h00_0050, 1'b1);
    endtask

    task automatic end_sim();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_reset_values();
        t_core_clock();
        t_ref_clock();
        t_irq_off();
        t_cvr_clear();
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule
